// file: hw/pviu_pkg.sv
// Package of constants for the prioritized vector interrupt unit
package pviu_pkg;
   // ----------------------------------------
   // Source numbering (bit index in request/enable vectors)
   // ----------------------------------------
   localparam int NUM_SRC = 13;            // Maskable sources with request/enable bits
   localparam int SRC_EXT_A = 0;           // Priority 2
   localparam int SRC_EXT_B = 1;           // Priority 3
   localparam int SRC_SER_RX = 2;          // Priority 4
   localparam int SRC_SER_TX = 3;          // Priority 5
   localparam int SRC_TMR_X = 4;           // Priority 6
   localparam int SRC_TMR_Y = 5;           // Priority 7
   localparam int SRC_TMR_2 = 6;           // Priority 8
   localparam int SRC_TMR_3 = 7;           // Priority 9
   localparam int SRC_CNT_A = 8;           // Priority 10
   localparam int SRC_CNT_B = 9;           // Priority 11
   localparam int SRC_TMR_1 = 10;          // Priority 12
   localparam int SRC_KEY = 11;            // Priority 13
   localparam int SRC_ADC = 12;            // Priority 14
   // ----------------------------------------
   // Vector table, low byte addresses (high byte is low + 1)
   // ----------------------------------------
   localparam logic [15:0] VEC_RESET = 16'hfffc;
   localparam logic [15:0] VEC_BREAK = 16'hffdc;
   localparam logic [15:0] VEC_LOW [NUM_SRC] = '{
      16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee,
      16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe0, 16'hffde};
   // ----------------------------------------
   // Priority codes reported with each acceptance
   // ----------------------------------------
   localparam logic [3:0] PRI_RESET = 4'h1;
   localparam logic [3:0] PRI_FIRST_SRC = 4'h2;
   localparam logic [3:0] PRI_BREAK = 4'hf;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [NUM_SRC-1:0] REQ_RST = 13'h0000;
   localparam logic [NUM_SRC-1:0] ENA_RST = 13'h0000;
   localparam logic [7:0] KEY_RST = 8'hff;
   // ----------------------------------------
   // Sequencer states, one-hot
   // ----------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,   // Waiting for a request
      ST_PCH = 7'h02,    // Push program counter high
      ST_PCL = 7'h04,    // Push program counter low
      ST_PS = 7'h08,     // Push status register
      ST_VLO = 7'h10,    // Fetch vector low byte
      ST_VHI = 7'h20,    // Fetch vector high byte
      ST_LOAD = 7'h40    // Load program counter
   } pviu_state_t;
endpackage

// file: hw/pviu_top.sv
// Prioritized vector interrupt unit: request latching, masking, priority and vectoring
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Maskable raise needs request, enable, disable flag clear
// R2 - Software sets/clears enables; requests clear only
// R3 - Disable flag masks all except break, reset
// R4 - Highest fixed priority accepted first, 1 highest
// R5 - Acceptance pushes program counter and status
// R6 - Acceptance sets disable flag, clears request
// R7 - Program counter loaded from vector entry
// R8 - Two-byte vectors from FFFC down to FFDC
// R9 - Reset is priority-1 non-maskable vector
// R10 - External pins request on selected edge
// R11 - Serial receive requests only when serial selected
// R12 - Serial transmit on shift done or empty
// R13 - Timer underflows request at fixed priorities
// R14 - Counter pins request on selected edge
// R15 - Keypad AND falling edge requests wake-up
// R16 - Converter requests only when selected on vector
// R17 - Break instruction: lowest, non-maskable, no bits
// R18 - Edge or source change may set request
// R19 - Software disables, changes, clears, then re-enables
// R20 - Fourteen sources plus reset supported
// R21 - Requests stay latched until accepted or cleared
module pviu_top (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   // Request sources
   input wire logic EXT_IRQ_PIN_A_I,
   input wire logic EXT_IRQ_PIN_B_I,
   input wire logic [1:0] EXT_EDGE_SELECT_I,
   input wire logic SER_SELECTED_I,
   input wire logic SER_RX_DONE_I,
   input wire logic SER_TX_SHIFT_DONE_I,
   input wire logic SER_TX_EMPTY_I,
   input wire logic SER_TX_ON_EMPTY_I,
   input wire logic [4:0] TMR_UNDERFLOW_I,
   input wire logic COUNTER_PIN_A_I,
   input wire logic COUNTER_PIN_B_I,
   input wire logic [1:0] CNT_EDGE_SELECT_I,
   input wire logic [7:0] KEYPAD_PORT_I,
   input wire logic [7:0] KEYPAD_DIR_OUT_I,
   input wire logic ADC_DONE_I,
   input wire logic ADC_IRQ_SELECT_I,
   input wire logic BREAK_INSTRUCTION_I,
   // Software access to request and enable bits
   input wire logic [12:0] REQ_CLR_I,
   input wire logic ENA_WR_I,
   input wire logic [12:0] ENA_WDATA_I,
   input wire logic IFLAG_CLR_I,
   input wire logic IFLAG_SET_I,
   // Core context
   input wire logic [15:0] CORE_PC_I,
   input wire logic [7:0] CORE_PS_I,
   input wire logic [7:0] CORE_RDATA_I,
   input wire logic CORE_ACK_I,
   // Core side outputs
   output logic [12:0] REQ_O,
   output logic [12:0] ENA_O,
   output logic IFLAG_O,
   output logic BUSY_O,
   output logic PUSH_O,
   output logic [7:0] PUSH_DATA_O,
   output logic FETCH_O,
   output logic [15:0] FETCH_ADDR_O,
   output logic PC_LOAD_O,
   output logic [15:0] PC_DATA_O,
   output logic [3:0] PRIORITY_O
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam int N = pviu_pkg::NUM_SRC;  // see R20
   pviu_pkg::pviu_state_t state_q;        // Sequencer state
   logic [N-1:0] req_q;                   // Latched requests
   logic [N-1:0] ena_q;                   // Enable bits
   logic iflag_q;                         // Global disable flag
   logic boot_q;                          // Reset vector still owed
   logic brk_q;                           // Break taken this round
   logic [3:0] sel_q;                     // Accepted source index
   logic [15:0] vec_q;                    // Vector low address
   logic [7:0] vlo_q;                     // Fetched low byte
   logic [7:0] push_q;                    // Byte being pushed
   logic [15:0] pcd_q;                    // Loaded program counter
   logic [3:0] pri_q;                     // Reported priority
   logic [1:0] ext_q;                     // Previous external pin levels
   logic [1:0] cnt_q;                     // Previous counter pin levels
   logic [1:0] exsel_q;                   // Previous external edge select
   logic [1:0] cnsel_q;                   // Previous counter edge select
   logic adsel_q;                         // Previous converter select
   logic key_and_q;                       // Previous keypad AND
   logic [N-1:0] evt;                     // Source events this cycle
   logic [N-1:0] pend;                    // Pending and enabled
   logic [3:0] win;                       // Winning index
   logic win_ok;                          // Any maskable winner
   logic [N-1:0] ack_clr;                 // Clear from acceptance
   logic key_and;                         // AND of input-mode keypad pins
   logic [1:0] ext_lv;                    // Current external levels
   logic [1:0] cnt_lv;                    // Current counter levels
   logic idle;                            // Sequencer is idle
   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   assign ext_lv = {EXT_IRQ_PIN_B_I, EXT_IRQ_PIN_A_I};
   assign cnt_lv = {COUNTER_PIN_B_I, COUNTER_PIN_A_I};
   assign key_and = &(KEYPAD_PORT_I | KEYPAD_DIR_OUT_I);   // Output pins drop out
   assign idle = (state_q == pviu_pkg::ST_IDLE);
   // Combine source events; select 1 means rising edge
   always_comb begin
      evt = '0;
      for (int i = 0; i < 2; i++) begin
         // Edge on chosen polarity, or select change side effect
         evt[pviu_pkg::SRC_EXT_A + i] = (EXT_EDGE_SELECT_I[i] ? (ext_lv[i] & ~ext_q[i])
            : (~ext_lv[i] & ext_q[i])) | (EXT_EDGE_SELECT_I[i] != exsel_q[i]); // see R10 R18
         evt[pviu_pkg::SRC_CNT_A + i] = (CNT_EDGE_SELECT_I[i] ? (cnt_lv[i] & ~cnt_q[i])
            : (~cnt_lv[i] & cnt_q[i])) | (CNT_EDGE_SELECT_I[i] != cnsel_q[i]); // see R14 R18
      end
      evt[pviu_pkg::SRC_SER_RX] = SER_RX_DONE_I & SER_SELECTED_I;                // see R11
      // Transmit trigger chosen between shift done and buffer empty
      evt[pviu_pkg::SRC_SER_TX] = SER_SELECTED_I &
         (SER_TX_ON_EMPTY_I ? SER_TX_EMPTY_I : SER_TX_SHIFT_DONE_I);             // see R12
      // Timer order on the vector: 0=X,1=Y,2=timer2,3=timer3,4=timer1
      evt[pviu_pkg::SRC_TMR_X] = TMR_UNDERFLOW_I[0];                            // see R13
      evt[pviu_pkg::SRC_TMR_Y] = TMR_UNDERFLOW_I[1];                            // see R13
      evt[pviu_pkg::SRC_TMR_2] = TMR_UNDERFLOW_I[2];                            // see R13
      evt[pviu_pkg::SRC_TMR_3] = TMR_UNDERFLOW_I[3];                            // see R13
      evt[pviu_pkg::SRC_TMR_1] = TMR_UNDERFLOW_I[4];                            // see R13
      evt[pviu_pkg::SRC_KEY] = key_and_q & ~key_and;                           // see R15
      // Converter shares its vector; switching the source may raise it
      evt[pviu_pkg::SRC_ADC] = (ADC_DONE_I & ADC_IRQ_SELECT_I) |
         (ADC_IRQ_SELECT_I != adsel_q);                                         // see R16 R18
   end

   // Previous levels for edge detection
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         // Track live levels in reset: release must not look like an edge or select change
         ext_q <= ext_lv;
         cnt_q <= cnt_lv;
         exsel_q <= EXT_EDGE_SELECT_I;
         cnsel_q <= CNT_EDGE_SELECT_I;
         adsel_q <= ADC_IRQ_SELECT_I;
         key_and_q <= key_and;
      end else begin
         ext_q <= ext_lv;
         cnt_q <= cnt_lv;
         exsel_q <= EXT_EDGE_SELECT_I;
         cnsel_q <= CNT_EDGE_SELECT_I;
         adsel_q <= ADC_IRQ_SELECT_I;
         key_and_q <= key_and;
      end
   end

   // ----------------------------------------
   // Priority selection
   // ----------------------------------------
   assign pend = req_q & ena_q;
   // Lowest index is highest priority; scan downward so it wins last
   always_comb begin
      win = 4'h0;
      win_ok = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i]) begin
            win = 4'(i);                                                         // see R4
            win_ok = 1'b1;
         end
      end
      win_ok = win_ok & ~iflag_q;                                               // see R1 R3
   end

   // ----------------------------------------
   // Request and enable bits
   // ----------------------------------------
   assign ack_clr = (idle && !boot_q && win_ok) ? (13'(1) << win) : '0;        // see R6

   // Requests latch; a new event beats any clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         req_q <= pviu_pkg::REQ_RST;
      end else begin
         req_q <= (req_q & ~(REQ_CLR_I | ack_clr)) | evt;                       // see R2 R21
      end
   end

   // Enables written whole by software
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         ena_q <= pviu_pkg::ENA_RST;
      end else if (ENA_WR_I) begin
         ena_q <= ENA_WDATA_I;                                                   // see R2
      end
   end

   // ----------------------------------------
   // Acceptance sequencer
   // ----------------------------------------
   // Disable flag: set by reset and every acceptance, cleared by software
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         iflag_q <= 1'b1;
      end else if (idle && (boot_q || win_ok || BREAK_INSTRUCTION_I)) begin
         iflag_q <= 1'b1;                                                        // see R6
      end else if (IFLAG_SET_I) begin
         iflag_q <= 1'b1;
      end else if (IFLAG_CLR_I) begin
         iflag_q <= 1'b0;
      end
   end

   // Context push and vector fetch; each bus step waits for core ack
   always_ff @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state_q <= pviu_pkg::ST_IDLE;
         boot_q <= 1'b1;
         brk_q <= 1'b0;
         sel_q <= 4'h0;
         vec_q <= pviu_pkg::VEC_RESET;
         vlo_q <= 8'h00;
         push_q <= 8'h00;
         pcd_q <= 16'h0000;
         pri_q <= 4'h0;
      end else begin
         unique case (state_q)
            pviu_pkg::ST_IDLE: begin
               if (boot_q) begin
                  // Reset acts as top-priority interrupt, no push
                  boot_q <= 1'b0;
                  vec_q <= pviu_pkg::VEC_RESET;                                  // see R9
                  pri_q <= pviu_pkg::PRI_RESET;
                  state_q <= pviu_pkg::ST_VLO;
               end else if (win_ok) begin
                  sel_q <= win;
                  vec_q <= pviu_pkg::VEC_LOW[win];                              // see R8
                  pri_q <= 4'(pviu_pkg::PRI_FIRST_SRC + win);
                  brk_q <= 1'b0;
                  push_q <= CORE_PC_I[15:8];
                  state_q <= pviu_pkg::ST_PCH;
               end else if (BREAK_INSTRUCTION_I) begin
                  // Break ignores every mask and has no bits
                  vec_q <= pviu_pkg::VEC_BREAK;                                  // see R17
                  pri_q <= pviu_pkg::PRI_BREAK;
                  brk_q <= 1'b1;
                  push_q <= CORE_PC_I[15:8];
                  state_q <= pviu_pkg::ST_PCH;
               end
            end
            pviu_pkg::ST_PCH: begin
               if (CORE_ACK_I) begin
                  push_q <= CORE_PC_I[7:0];                                      // see R5
                  state_q <= pviu_pkg::ST_PCL;
               end
            end
            pviu_pkg::ST_PCL: begin
               if (CORE_ACK_I) begin
                  push_q <= CORE_PS_I;                                           // see R5
                  state_q <= pviu_pkg::ST_PS;
               end
            end
            pviu_pkg::ST_PS: begin
               if (CORE_ACK_I) begin
                  state_q <= pviu_pkg::ST_VLO;
               end
            end
            pviu_pkg::ST_VLO: begin
               if (CORE_ACK_I) begin
                  vlo_q <= CORE_RDATA_I;
                  state_q <= pviu_pkg::ST_VHI;
               end
            end
            pviu_pkg::ST_VHI: begin
               if (CORE_ACK_I) begin
                  pcd_q <= {CORE_RDATA_I, vlo_q};                                // see R7
                  state_q <= pviu_pkg::ST_LOAD;
               end
            end
            pviu_pkg::ST_LOAD: begin
               state_q <= pviu_pkg::ST_IDLE;
            end
            default: begin
               state_q <= pviu_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign REQ_O = req_q;
   assign ENA_O = ena_q;
   assign IFLAG_O = iflag_q;
   assign BUSY_O = ~idle;
   assign PUSH_O = (state_q == pviu_pkg::ST_PCH) || (state_q == pviu_pkg::ST_PCL) ||
                   (state_q == pviu_pkg::ST_PS);
   assign PUSH_DATA_O = push_q;
   assign FETCH_O = (state_q == pviu_pkg::ST_VLO) || (state_q == pviu_pkg::ST_VHI);
   // High byte sits one above the low byte
   assign FETCH_ADDR_O = (state_q == pviu_pkg::ST_VHI) ? (vec_q | 16'h0001) : vec_q;
   assign PC_LOAD_O = (state_q == pviu_pkg::ST_LOAD);
   assign PC_DATA_O = pcd_q;
   assign PRIORITY_O = pri_q;
endmodule // pviu_top

// file: verif/pviu_chk.sv
// Checker of the interrupt unit port behaviour
`timescale 1ns/1ns
module pviu_chk (
   // Clock, reset and inputs
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic BREAK_INSTRUCTION_I,
   input wire logic [12:0] REQ_CLR_I,
   input wire logic ENA_WR_I,
   input wire logic [12:0] ENA_WDATA_I,
   input wire logic CORE_ACK_I,
   input wire logic [7:0] CORE_RDATA_I,
   // Outputs
   input wire logic [12:0] REQ_O,
   input wire logic [12:0] ENA_O,
   input wire logic IFLAG_O,
   input wire logic BUSY_O,
   input wire logic PUSH_O,
   input wire logic FETCH_O,
   input wire logic [15:0] FETCH_ADDR_O,
   input wire logic PC_LOAD_O,
   input wire logic [15:0] PC_DATA_O,
   input wire logic [3:0] PRIORITY_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // Acceptance edge and the two vector fetch steps
   sequence s_accept; $rose(BUSY_O) && PUSH_O; endsequence
   sequence s_lo_done; FETCH_O && CORE_ACK_I && !FETCH_ADDR_O[0]; endsequence
   sequence s_hi_done; FETCH_O && CORE_ACK_I && FETCH_ADDR_O[0]; endsequence
   chk_masked_no_push: assert property (
      !BUSY_O && !BREAK_INSTRUCTION_I && (IFLAG_O || (REQ_O & ENA_O) == 13'h0) |=> !PUSH_O)
      else $error("push without an unmasked cause");
   chk_accept_flag: assert property (s_accept |-> IFLAG_O)
      else $error("disable flag not set on acceptance");
   chk_prio_order: assert property (
      (s_accept and (PRIORITY_O inside {[2:14]})) |-> !REQ_O[PRIORITY_O - 4'h2] &&
      ($past(REQ_O & ENA_O) & ((13'h1 << (PRIORITY_O - 4'h2)) - 13'h1)) == 13'h0)
      else $error("wrong winner or request kept");
   chk_push_order: assert property (PUSH_O && CORE_ACK_I |=> PUSH_O || FETCH_O)
      else $error("push step not followed by push or fetch");
   chk_vec_pair: assert property (
      s_lo_done |=> FETCH_O && FETCH_ADDR_O == $past(FETCH_ADDR_O) + 16'h1)
      else $error("vector high byte address wrong");
   chk_pc_from_vec: assert property (
      s_hi_done |=> PC_LOAD_O && PC_DATA_O[15:8] == $past(CORE_RDATA_I))
      else $error("program counter not loaded from vector");
   chk_reset_vector: assert property (
      $rose(RESET_N_I) |=> FETCH_O && !PUSH_O && PRIORITY_O == 4'h1 && FETCH_ADDR_O == 16'hfffc)
      else $error("reset vector sequence missing");
   chk_req_hold: assert property (
      (~REQ_O & $past(REQ_O) & ~$past(REQ_CLR_I)) != 13'h0 |-> $rose(BUSY_O))
      else $error("request dropped without cause");
   chk_ena_write: assert property (ENA_WR_I |=> ENA_O == $past(ENA_WDATA_I))
      else $error("enable write lost");
endmodule // pviu_chk

// file: verif/pviu_core_model.sv
// Behavioural core that answers push and fetch steps
`timescale 1ns/1ns
module pviu_core_model (
   // Clock and pacing
   input wire logic clk_i,
   input wire logic slow_i,
   // Steps from the unit
   input wire logic push_i,
   input wire logic fetch_i,
   input wire logic [15:0] fetch_addr_i,
   // Answer
   output logic ack_o,
   output logic [7:0] rdata_o
);
   logic [1:0] wait_q = 2'h0; // Stall count in slow mode
   initial ack_o = 1'b0;
   initial rdata_o = 8'h00;
   // One ack per step; the byte only means something with ack
   always @(posedge clk_i) begin
      if ((push_i || fetch_i) && !ack_o && (!slow_i || wait_q == 2'h3)) begin
         ack_o <= 1'b1;
         rdata_o <= fetch_addr_i[7:0] ^ 8'h3c;
         wait_q <= 2'h0;
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o; // Never leave a stale byte standing
         wait_q <= (push_i || fetch_i) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule // pviu_core_model

// file: verif/pviu_top_tb.sv
// Testbench of the prioritized vector interrupt unit
`timescale 1ns/1ns
module pviu_top_tb;
   // Stimulus, all with time-zero values
   logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, ext_a = 1'b0, ext_b = 1'b0, ser_sel = 1'b1;
   logic rx = 1'b0, tx_sh = 1'b0, tx_em = 1'b0, tx_on_em = 1'b0, cnt_a = 1'b0, cnt_b = 1'b0;
   logic adc = 1'b0, adc_sel = 1'b1, break_instruction = 1'b0, ena_wr = 1'b0, fl_clr = 1'b0, fl_set = 1'b0;
   logic [1:0] ext_sel = 2'h3, cnt_sel = 2'h3;
   logic [4:0] tmr = 5'h00;
   logic [7:0] key = 8'hff, kdir = 8'h00;
   logic [12:0] req_clr = 13'h0000, ena_wd = 13'h0000;
   // Observed
   logic ack, iflag, busy, push, fetch, pc_load;
   logic [7:0] rdata, push_data;
   logic [12:0] req, ena;
   logic [15:0] f_addr, pc_data;
   logic [3:0] prio;
   int mismatches = 0, total_checks = 0;
   localparam logic [15:0] CTX_PC = 16'h1234; // Core context held still
   localparam logic [7:0] CTX_PS = 8'h5a;
   always #2 clk = ~clk; // 250 MHz
   pviu_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .EXT_IRQ_PIN_A_I(ext_a),
      .EXT_IRQ_PIN_B_I(ext_b), .EXT_EDGE_SELECT_I(ext_sel), .SER_SELECTED_I(ser_sel),
      .SER_RX_DONE_I(rx), .SER_TX_SHIFT_DONE_I(tx_sh), .SER_TX_EMPTY_I(tx_em),
      .SER_TX_ON_EMPTY_I(tx_on_em), .TMR_UNDERFLOW_I(tmr), .COUNTER_PIN_A_I(cnt_a),
      .COUNTER_PIN_B_I(cnt_b), .CNT_EDGE_SELECT_I(cnt_sel), .KEYPAD_PORT_I(key),
      .KEYPAD_DIR_OUT_I(kdir), .ADC_DONE_I(adc), .ADC_IRQ_SELECT_I(adc_sel),
      .BREAK_INSTRUCTION_I(break_instruction), .REQ_CLR_I(req_clr), .ENA_WR_I(ena_wr), .ENA_WDATA_I(ena_wd),
      .IFLAG_CLR_I(fl_clr), .IFLAG_SET_I(fl_set),
      .CORE_PC_I(CTX_PC), .CORE_PS_I(CTX_PS), .CORE_RDATA_I(rdata), .CORE_ACK_I(ack),
      .REQ_O(req), .ENA_O(ena), .IFLAG_O(iflag), .BUSY_O(busy), .PUSH_O(push),
      .PUSH_DATA_O(push_data), .FETCH_O(fetch), .FETCH_ADDR_O(f_addr), .PC_LOAD_O(pc_load),
      .PC_DATA_O(pc_data), .PRIORITY_O(prio));
   pviu_core_model i_core (.clk_i(clk), .slow_i(slow), .push_i(push), .fetch_i(fetch),
      .fetch_addr_i(f_addr), .ack_o(ack), .rdata_o(rdata));
   // Compare one result
   task automatic cmp(input logic [15:0] a, input logic [15:0] e);
      total_checks++;
      if (a !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, a, e);
      end
   endtask
   // One-cycle event of source i (13 is transmit buffer empty)
   task automatic fire(input int i);
      @(posedge clk);
      case (i)
         0: ext_a <= 1'b1;
         1: ext_b <= 1'b1;
         2: rx <= 1'b1;
         3: tx_sh <= 1'b1;
         8: cnt_a <= 1'b1;
         9: cnt_b <= 1'b1;
         10: tmr[4] <= 1'b1;
         11: key[3] <= 1'b0;
         12: adc <= 1'b1;
         13: tx_em <= 1'b1;
         default: tmr[i - 4] <= 1'b1;
      endcase
      @(posedge clk);
      {ext_a, ext_b, rx, tx_sh, tx_em, cnt_a, cnt_b, adc, tmr} <= 13'h0;
      key <= 8'hff;
   endtask
   // Software strobe: 0 enable write, 1 flag clear, 3 flag set, else request clear
   task automatic ctl(input int k, input logic [12:0] v);
      @(posedge clk);
      case (k)
         0: begin ena_wr <= 1'b1; ena_wd <= v; end
         1: fl_clr <= 1'b1;
         3: fl_set <= 1'b1;
         default: req_clr <= v;
      endcase
      @(posedge clk);
      {ena_wr, fl_clr, fl_set} <= 3'b000;
      req_clr <= 13'h0;
   endtask
   // Follow one vectoring sequence to its load and judge it
   task automatic run(input logic [3:0] p, input logic [15:0] lo, input bit pu);
      logic [15:0] got[$];
      int n;
      n = 0;
      while (pc_load !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
         if (ack === 1'b1 && push === 1'b1) got.push_back({8'h00, push_data});
         if (ack === 1'b1 && fetch === 1'b1) got.push_back(f_addr);
      end
      cmp({15'h0, pc_load}, 16'h1);
      cmp(16'(got.size()), pu ? 16'h5 : 16'h2);
      if (pu) begin
         cmp(got.pop_front(), {8'h00, CTX_PC[15:8]});
         cmp(got.pop_front(), {8'h00, CTX_PC[7:0]});
         cmp(got.pop_front(), {8'h00, CTX_PS});
      end
      cmp(got.pop_front(), lo);
      cmp(got.pop_front(), lo | 16'h1);
      cmp(pc_data, {(lo[7:0] | 8'h01) ^ 8'h3c, lo[7:0] ^ 8'h3c});
      cmp({12'h0, prio}, {12'h0, p});
      cmp({15'h0, iflag}, 16'h1);
   endtask
   // Reset, reset values, reset vector
   task automatic t_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp({3'h0, req | ena}, 16'h0);
      run(pviu_pkg::PRI_RESET, pviu_pkg::VEC_RESET, 1'b0);
   endtask
   // Request held while masked by enable, then by flag
   task automatic t_mask;
      fire(4);
      repeat (4) @(negedge clk);
      cmp({2'h0, busy, req}, 16'h0010);
      ctl(0, 13'h1fff);
      repeat (4) @(negedge clk);
      cmp({2'h0, busy, ena}, 16'h1fff);
      cmp({3'h0, req}, 16'h0010);
      ctl(1, 13'h0);
      run(4'h6, 16'hfff2, 1'b1);
      cmp({3'h0, req}, 16'h0);
   endtask
   // Every source pending at once, slow core, then break
   task automatic t_all;
      @(posedge clk);
      slow <= 1'b1;
      for (int i = 12; i >= 0; i--) fire(i);
      @(negedge clk);
      cmp({3'h0, req}, 16'h1fff);
      for (int i = 0; i < 13; i++) begin
         ctl(1, 13'h0);
         run(pviu_pkg::PRI_FIRST_SRC + 4'(i), pviu_pkg::VEC_LOW[i], 1'b1);
      end
      @(posedge clk);
      break_instruction <= 1'b1;
      do @(negedge clk); while (busy !== 1'b1);
      @(posedge clk);
      break_instruction <= 1'b0;
      run(pviu_pkg::PRI_BREAK, pviu_pkg::VEC_BREAK, 1'b1);
   endtask
   // Serial gating, select side effects, safe reselect order
   task automatic t_sw;
      @(posedge clk);
      ser_sel <= 1'b0;
      fire(2);
      @(posedge clk);
      {ser_sel, tx_on_em} <= 2'b11;
      fire(3);
      fire(13);
      @(negedge clk);
      cmp({3'h0, req}, 16'h0008);
      ctl(0, 13'h0000);
      @(posedge clk);
      ext_sel <= 2'h2;
      adc_sel <= 1'b0;
      repeat (3) @(negedge clk);
      cmp({3'h0, req}, 16'h1009);
      // Output-mode keypad pin ignored; pin a now on falling edge; counter select change
      @(posedge clk);
      {kdir, cnt_sel} <= {8'h08, 2'h2};
      fire(11);
      fire(0);
      repeat (2) @(negedge clk);
      cmp({3'h0, req}, 16'h1109);
      ctl(2, 13'h1109);
      @(negedge clk);
      cmp({3'h0, req}, 16'h0);
      ctl(0, 13'h1fff);
      ctl(1, 13'h0);
      repeat (4) @(negedge clk);
      cmp({14'h0, busy, iflag}, 16'h0);
      ctl(3, 13'h0);
      @(negedge clk);
      cmp({15'h0, iflag}, 16'h1);
   endtask
   // Verdict and end of run
   task automatic final_report;
      if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      t_reset();
      t_mask();
      t_all();
      t_sw();
      t_reset();
      final_report();
   end
   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #(4 * 20000);
      mismatches++;
      final_report();
   end
endmodule // pviu_top_tb
bind pviu_top pviu_chk i_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
   .BREAK_INSTRUCTION_I(BREAK_INSTRUCTION_I), .REQ_CLR_I(REQ_CLR_I), .ENA_WR_I(ENA_WR_I),
   .ENA_WDATA_I(ENA_WDATA_I), .CORE_ACK_I(CORE_ACK_I), .CORE_RDATA_I(CORE_RDATA_I),
   .REQ_O(REQ_O), .ENA_O(ENA_O), .IFLAG_O(IFLAG_O), .BUSY_O(BUSY_O), .PUSH_O(PUSH_O),
   .FETCH_O(FETCH_O), .FETCH_ADDR_O(FETCH_ADDR_O), .PC_LOAD_O(PC_LOAD_O),
   .PC_DATA_O(PC_DATA_O), .PRIORITY_O(PRIORITY_O));
